// [common/srt_cal_if.sv]
// interface: link between serial access logic and the timekeeping counters
`timescale 1ns/10ps
interface srt_cal_if;
  logic        tick;
  logic        load;
  logic [51:0] load_frame;
  logic [51:0] frame;
  modport ctl (output tick, output load, output load_frame, input frame);
  modport cal (input tick, input load, input load_frame, output frame);
endinterface : srt_cal_if

// [common/srt_pkg.sv]
// package: frame layout, timing counts and reset values for the serial clock block
package srt_pkg;
  localparam int          SRT_FRAME_W      = 52;
  localparam int          SRT_CNT_W        = 6;
  localparam logic [5:0]  SRT_LAST_BIT     = 6'h33;
  localparam logic [5:0]  SRT_FRAME_BITS   = 6'h34;
  // field lsb positions inside the frame
  localparam int          SRT_SEC_LSB      = 0;
  localparam int          SRT_MIN_LSB      = 8;
  localparam int          SRT_HOUR_LSB     = 16;
  localparam int          SRT_WDAY_LSB     = 24;
  localparam int          SRT_DAY_LSB      = 28;
  localparam int          SRT_MON_LSB      = 36;
  localparam int          SRT_YEAR_LSB     = 44;
  localparam int          SRT_LV_POS       = 7;
  localparam int          SRT_TM_POS       = 43;
  // calendar reset values
  localparam logic [6:0]  SRT_SEC_RST      = 7'h00;
  localparam logic [6:0]  SRT_MIN_RST      = 7'h00;
  localparam logic [5:0]  SRT_HOUR_RST     = 6'h00;
  localparam logic [2:0]  SRT_WDAY_RST     = 3'h1;
  localparam logic [5:0]  SRT_DAY_RST      = 6'h01;
  localparam logic [4:0]  SRT_MON_RST      = 5'h01;
  localparam logic [7:0]  SRT_YEAR_RST     = 8'h00;
  // timing
  localparam int          SRT_SYS_CLK_HZ   = 40_000_000;
  localparam int          SRT_SUB_HZ       = 128;
  localparam int          SRT_TICK_DIV_DEF = SRT_SYS_CLK_HZ / SRT_SUB_HZ;
  localparam int          SRT_TICK_W       = 19;
  localparam int          SRT_FREQ_OUTPUT_DLY_US  = 15600;
  localparam logic [6:0]  SRT_FREQ_OUTPUT_DLY     = 7'((SRT_FREQ_OUTPUT_DLY_US * SRT_SUB_HZ + 500_000) / 1_000_000);
  localparam int          SRT_LV_PERIOD_MS = 500;
  localparam logic [5:0]  SRT_LV_LAST      = 6'((SRT_LV_PERIOD_MS * SRT_SUB_HZ) / 1000 - 1);
  localparam logic [6:0]  SRT_SUB_LAST     = 7'h7f;
  // avalon register map, byte addresses
  localparam logic [3:0]  SRT_REG_STATUS   = 4'h0;
  localparam logic [3:0]  SRT_REG_CTRL     = 4'h4;
  localparam logic [3:0]  SRT_REG_TIME_LO  = 4'h8;
  localparam logic [3:0]  SRT_REG_TIME_HI  = 4'hc;
  localparam int          SRT_CTRL_FOE     = 0;
  localparam logic        SRT_CTRL_FOE_RST = 1'b1;

  function automatic logic [7:0] srt_bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return {v[7:4], v[3:0] + 4'h1};
  endfunction : srt_bcd_inc

  function automatic logic [5:0] srt_month_days(input logic [4:0] mon, input logic [7:0] year);
    logic leap;
    leap = (~year[4] & (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8)) |
           (year[4] & (year[3:0] == 4'h2 || year[3:0] == 4'h6));
    if (mon == 5'h02) begin
      return leap ? 6'h29 : 6'h28;
    end
    if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11) begin
      return 6'h30;
    end
    return 6'h31;
  endfunction : srt_month_days
endpackage : srt_pkg

// [rtl/srt_calendar.sv]
// bcd time and calendar counters with parallel load
`timescale 1ns/10ps
module srt_calendar import srt_pkg::*; (
  // clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  // access side
  srt_cal_if.cal    cif
);
  logic [6:0] sec;
  logic [6:0] min;
  logic [5:0] hour;
  logic [2:0] wday;
  logic [5:0] day;
  logic [4:0] mon;
  logic       test_bit;
  logic [7:0] year;
  logic [7:0] next_sec;
  logic [7:0] next_min;
  logic [7:0] next_hour;
  logic [7:0] next_day;
  logic [7:0] next_mon;
  logic [7:0] next_year;
  logic       sec_w;
  logic       min_w;
  logic       hour_w;
  logic       day_w;
  logic       mon_w;

  always_comb begin
    next_sec  = srt_bcd_inc({1'b0, sec});
    next_min  = srt_bcd_inc({1'b0, min});
    next_hour = srt_bcd_inc({2'b0, hour});
    next_day  = srt_bcd_inc({2'b0, day});
    next_mon  = srt_bcd_inc({3'b0, mon});
    next_year = srt_bcd_inc(year);
    sec_w     = (sec == 7'h59);
    min_w     = sec_w & (min == 7'h59);
    hour_w    = min_w & (hour == 6'h23);
    day_w     = hour_w & (day == srt_month_days(mon, year));
    mon_w     = day_w & (mon == 5'h12);
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sec      <= SRT_SEC_RST;
      min      <= SRT_MIN_RST;
      hour     <= SRT_HOUR_RST;
      wday     <= SRT_WDAY_RST;
      day      <= SRT_DAY_RST;
      mon      <= SRT_MON_RST;
      test_bit <= 1'b0;
      year     <= SRT_YEAR_RST;
    end else if (cif.load) begin
      sec      <= cif.load_frame[SRT_SEC_LSB +: 7];
      min      <= cif.load_frame[SRT_MIN_LSB +: 7];
      hour     <= cif.load_frame[SRT_HOUR_LSB +: 6];
      wday     <= cif.load_frame[SRT_WDAY_LSB +: 3];
      day      <= cif.load_frame[SRT_DAY_LSB +: 6];
      mon      <= cif.load_frame[SRT_MON_LSB +: 5];
      test_bit <= cif.load_frame[SRT_TM_POS];
      year     <= cif.load_frame[SRT_YEAR_LSB +: 8];
    end else if (cif.tick) begin
      sec <= sec_w ? 7'h00 : next_sec[6:0];
      if (sec_w) begin
        min <= min_w ? 7'h00 : next_min[6:0];
      end
      if (min_w) begin
        hour <= hour_w ? 6'h00 : next_hour[5:0];
      end
      if (hour_w) begin
        wday <= (wday == 3'h7) ? 3'h1 : wday + 3'h1;
        day  <= day_w ? 6'h01 : next_day[5:0];
      end
      if (day_w) begin
        mon <= mon_w ? 5'h01 : next_mon[4:0];
      end
      if (mon_w) begin
        year <= (year == 8'h99) ? 8'h00 : next_year;
      end
    end
  end

  // unused frame bits read as zero; low-voltage slot is filled by the access logic
  assign cif.frame = {year, test_bit, 2'b00, mon, 2'b00, day, 1'b0, wday, 2'b00, hour, 1'b0, min, 1'b0, sec};
endmodule : srt_calendar

// [rtl/srt_top.sv]
// serial three-wire time and calendar access with divider, frequency output and avalon status port
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
module srt_top import srt_pkg::*; #(
  parameter int TICK_DIV = SRT_TICK_DIV_DEF
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // serial host pins
  input  wire logic        i_access_en,
  input  wire logic        i_write_sel,
  input  wire logic        i_serial_clk,
  input  wire logic        i_data,
  output logic             o_data,
  output logic             o_data_oe,
  // supply monitor and frequency output
  input  wire logic        i_supply_low,
  output logic             o_freq_output,
  // avalon-mm slave
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest
);
  srt_cal_if cif ();

  // pin synchronisers
  logic [1:0]             ce_s;
  logic [1:0]             wr_s;
  logic [1:0]             sclk_s;
  logic [1:0]             din_s;
  logic [1:0]             vlow_s;
  logic                   sclk_d;
  logic                   ce;
  logic                   rd_mode;
  logic                   wr_mode;
  logic                   sclk_rise;
  logic                   sclk_fall;
  // serial state
  logic [SRT_CNT_W-1:0]   bit_cnt;
  logic [SRT_FRAME_W-1:0] shreg;
  logic [SRT_FRAME_W-1:0] snap;
  logic                   lv_flag;
  logic                   load;
  logic [SRT_FRAME_W-1:0] load_frame;
  // divider state
  logic [SRT_TICK_W-1:0]  tick_cnt;
  logic                   sub_tick;
  logic [6:0]             sub_cnt;
  logic [6:0]             freq_output_phase;
  logic                   div_hold;
  logic                   carry_hold;
  logic                   sec_carry;
  logic                   freq_out;
  // registers
  logic                   foe;
  logic                   ack;
  logic                   bus_req;
  logic [31:0]            rdata;
  logic [31:0]            next_rdata;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ce_s   <= 2'b00;
      wr_s   <= 2'b00;
      sclk_s <= 2'b00;
      din_s  <= 2'b00;
      vlow_s <= 2'b00;
      sclk_d <= 1'b0;
    end else begin
      ce_s   <= {ce_s[0], i_access_en};
      wr_s   <= {wr_s[0], i_write_sel};
      sclk_s <= {sclk_s[0], i_serial_clk};
      din_s  <= {din_s[0], i_data};
      vlow_s <= {vlow_s[0], i_supply_low};
      sclk_d <= sclk_s[1];
    end
  end

  assign ce        = ce_s[1];
  assign rd_mode   = ce & ~wr_s[1];
  assign wr_mode   = ce & wr_s[1];
  assign sclk_rise = sclk_s[1] & ~sclk_d;
  assign sclk_fall = ~sclk_s[1] & sclk_d;

  // bit counter saturates at the frame length
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt <= '0;
    end else if (!ce) begin
      bit_cnt <= '0;
    end else if (sclk_rise && bit_cnt != SRT_FRAME_BITS) begin
      bit_cnt <= bit_cnt + 6'h01;
    end
  end

  // the snapshot is taken once, so a carry mid-read only costs at most one second
  assign snap = {cif.frame[SRT_FRAME_W-1:SRT_LV_POS+1], lv_flag, cif.frame[SRT_LV_POS-1:0]};

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      shreg <= '0;
    end else if (sclk_rise && rd_mode) begin
      if (bit_cnt == '0) begin
        shreg <= snap;
      end else if (bit_cnt != SRT_FRAME_BITS) begin
        shreg <= {1'b0, shreg[SRT_FRAME_W-1:1]};
      end
    end else if (sclk_rise && wr_mode && bit_cnt != SRT_FRAME_BITS) begin
      shreg <= {din_s[1], shreg[SRT_FRAME_W-1:1]};
    end
  end

  // commit only on the final bit; an aborted write never reaches the counters
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      load       <= 1'b0;
      load_frame <= '0;
    end else begin
      load <= sclk_rise & wr_mode & (bit_cnt == SRT_LAST_BIT);
      if (sclk_rise && wr_mode && bit_cnt == SRT_LAST_BIT) begin
        load_frame <= {din_s[1], shreg[SRT_FRAME_W-1:1]};
      end
    end
  end

  assign cif.load       = load;
  assign cif.load_frame = load_frame;

  // low-voltage flag: set beats clear when both land together
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      lv_flag <= 1'b0;
    end else begin
      if (sclk_rise && rd_mode && bit_cnt == SRT_LAST_BIT) begin
        lv_flag <= 1'b0;
      end
      if (load) begin
        lv_flag <= load_frame[SRT_LV_POS];
      end
      if (sub_tick && sub_cnt[5:0] == SRT_LV_LAST && vlow_s[1]) begin
        lv_flag <= 1'b1;
      end
    end
  end

  // 128 Hz prescaler keeps running through a write, giving the +0 / -7.8 ms phase
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      tick_cnt <= '0;
      sub_tick <= 1'b0;
    end else if (tick_cnt == SRT_TICK_W'(TICK_DIV - 1)) begin
      tick_cnt <= '0;
      sub_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 19'h00001;
      sub_tick <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_hold <= 1'b0;
    end else if (!ce || sclk_rise) begin
      div_hold <= 1'b0;
    end else if (sclk_fall && wr_mode && bit_cnt == 6'h01) begin
      div_hold <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      carry_hold <= 1'b0;
    end else if (!ce) begin
      carry_hold <= 1'b0;
    end else if (sclk_fall && wr_mode && bit_cnt == 6'h01) begin
      carry_hold <= 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sub_cnt <= '0;
    end else if (div_hold || (sclk_fall && wr_mode && bit_cnt == 6'h01)) begin
      sub_cnt <= '0;
    end else if (sub_tick) begin
      sub_cnt <= sub_cnt + 7'h01;
    end
  end

  assign sec_carry = sub_tick & (sub_cnt == SRT_SUB_LAST) & ~div_hold;
  assign cif.tick  = sec_carry & ~carry_hold;

  // internal 1 Hz is high in the second half; the output lags it by two sub ticks
  assign freq_output_phase = sub_cnt - SRT_FREQ_OUTPUT_DLY;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      freq_out <= 1'b0;
    end else begin
      freq_out <= foe & freq_output_phase[6];
    end
  end

  assign o_freq_output = freq_out;

  // data pin is driven only while reading
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_data    <= 1'b0;
      o_data_oe <= 1'b0;
    end else begin
      o_data    <= shreg[0];
      o_data_oe <= rd_mode;
    end
  end

  srt_calendar u_calendar (
    .i_sys_clk (i_sys_clk),
    .i_rstn    (i_rstn),
    .cif       (cif.cal)
  );

  // avalon slave: one wait state, answer on the following edge
  assign bus_req           = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack;
  assign o_avs_readdata    = rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (i_avs_address)
      SRT_REG_STATUS:  next_rdata = {22'h000000, bit_cnt, carry_hold, lv_flag, wr_mode, ce};
      SRT_REG_CTRL:    next_rdata = {31'h00000000, foe};
      SRT_REG_TIME_LO: next_rdata = snap[31:0];
      SRT_REG_TIME_HI: next_rdata = {12'h000, snap[SRT_FRAME_W-1:32]};
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ack   <= 1'b0;
      rdata <= '0;
    end else begin
      ack <= bus_req & ~ack;
      if (i_avs_read && !ack) begin
        rdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      foe <= SRT_CTRL_FOE_RST;
    end else if (i_avs_write && ack && i_avs_address == SRT_REG_CTRL && i_avs_byteenable[0]) begin
      foe <= i_avs_writedata[SRT_CTRL_FOE];
    end
  end
endmodule : srt_top

// [testbench/srt_host_model.sv]
// host model: drives enable, direction, serial clock and the shared data line
`timescale 1ns/10ps
module srt_host_model (
  // clock
  input  wire logic i_sys_clk,
  // device data pin halves
  input  wire logic i_dev_data,
  input  wire logic i_dev_oe,
  // host pins
  output logic      o_access_en,
  output logic      o_write_sel,
  output logic      o_serial_clk,
  output logic      o_line
);
  localparam int HALF = 16;
  localparam int RCV  = 40;
  logic drv;
  logic bitv;
  logic junk;
  initial begin
    {o_access_en, o_write_sel, o_serial_clk, drv, bitv, junk} = 6'h00;
  end
  // released line has no pull: show a changing pattern, not the last bit
  always @(posedge i_sys_clk) junk <= ~junk;
  assign o_line = i_dev_oe ? i_dev_data : (drv ? bitv : junk);
  // n pulses; fewer than 52 ends the access early
  task automatic xfer(input logic wr, input int n, input logic [51:0] wf, output logic [51:0] rf);
    rf = 52'h0;
    o_write_sel <= wr;
    drv         <= wr;
    @(posedge i_sys_clk);
    o_access_en <= 1'b1;
    repeat (HALF) @(posedge i_sys_clk);
    for (int k = 0; k < n; k++) begin
      bitv <= (k < 52) ? wf[k % 52] : ~wf[k % 52];
      repeat (HALF) @(posedge i_sys_clk);
      o_serial_clk <= 1'b1;
      repeat (HALF) @(posedge i_sys_clk);
      if (k < 52) rf[k] = o_line;
      o_serial_clk <= 1'b0;
    end
    repeat (HALF) @(posedge i_sys_clk);
    o_access_en <= 1'b0;
    drv         <= 1'b0;
    repeat (RCV) @(posedge i_sys_clk);
  endtask : xfer
endmodule : srt_host_model

// [testbench/srt_top_chk.sv]
// checker: port-level timing of the serial pins, avalon handshake and frequency output
`timescale 1ns/10ps
module srt_top_chk import srt_pkg::*; #(
  parameter int TICK_DIV = SRT_TICK_DIV_DEF
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  // serial pins
  input  wire logic        i_access_en,
  input  wire logic        i_write_sel,
  input  wire logic        i_serial_clk,
  input  wire logic        i_data,
  input  wire logic        o_data,
  input  wire logic        o_data_oe,
  // supply and frequency output
  input  wire logic        i_supply_low,
  input  wire logic        o_freq_output,
  // avalon
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] o_avs_readdata,
  input  wire logic        o_avs_waitrequest
);
  localparam int HI_MAX = 64 * TICK_DIV;
  logic        sck_q;
  logic [7:0]  since_rise;
  logic [6:0]  rises;
  logic [31:0] hi_len;
  wire logic   rise;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  assign rise = i_serial_clk && !sck_q;
  // raw pin edges; the design sees them a few cycles later, hence the slack below
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_q      <= 1'b0;
      since_rise <= 8'hff;
      rises      <= 7'h00;
      hi_len     <= 32'h0;
    end else begin
      sck_q      <= i_serial_clk;
      since_rise <= rise ? 8'h00 : (since_rise == 8'hff ? since_rise : since_rise + 8'h01);
      rises      <= !i_access_en ? 7'h00 : ((rise && rises != 7'h7f) ? rises + 7'h01 : rises);
      hi_len     <= o_freq_output ? hi_len + 32'h1 : 32'h0;
    end
  end
  sequence s_req;
    $rose(i_avs_read || i_avs_write);
  endsequence
  sequence s_one_wait;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  a_oe_read_mode: assert property ((i_access_en && !i_write_sel) [*6] |-> o_data_oe)
    else $error("data not driven in read mode");
  a_oe_write_off: assert property ((i_access_en && i_write_sel) [*6] |-> !o_data_oe)
    else $error("data driven in write mode");
  a_oe_idle_off: assert property (!i_access_en [*6] |-> !o_data_oe)
    else $error("data driven while disabled");
  a_data_between_rises: assert property (o_data_oe && $past(o_data_oe) && since_rise > 8'd10 |-> $stable(o_data))
    else $error("data changed without a clock rise");
  a_data_after_last: assert property (o_data_oe && $past(o_data_oe) && rises > 7'd52 |-> $stable(o_data))
    else $error("data changed after the last bit");
  a_avs_one_wait: assert property (s_req |-> s_one_wait)
    else $error("avalon wait not one cycle");
  a_avs_idle: assert property (!(i_avs_read || i_avs_write) |-> !o_avs_waitrequest)
    else $error("waitrequest without request");
  a_freq_output_high_len: assert property (hi_len <= 32'(HI_MAX))
    else $error("frequency output high too long");
endmodule : srt_top_chk

// [testbench/srt_top_tb.sv]
// testbench: serial access, calendar, frequency output and status port of srt_top
`timescale 1ns/10ps
module srt_top_tb import srt_pkg::*; ();
  localparam int TDIV  = 64;
  localparam int SEC   = 128 * TDIV;
  localparam int LIMIT = 90000;
  localparam logic [51:0] F_RST  = {8'h00, 8'h01, 8'h01, 4'h1, 8'h00, 8'h00, 8'h00};
  localparam logic [51:0] F_W    = {8'h24, 8'h12, 8'h31, 4'h5, 8'h23, 8'h59, 8'h58};
  localparam logic [51:0] F_ROLL = {8'h25, 8'h01, 8'h01, 4'h6, 8'h00, 8'h00, 8'h00};
  localparam logic [51:0] F_CUT  = {8'h99, 8'h07, 8'h15, 4'h2, 8'h10, 8'h30, 8'h20};
  logic        clk, rstn, supply_low, avs_rd, avs_wr, avs_wait, dout, doe, freq_output, en, sel, sck, line;
  logic [3:0]  avs_addr;
  logic [31:0] avs_wd, avs_rdata;
  int          failures = 0;
  int          checks   = 0;
  int          cyc      = 0;
  int          w_end;
  srt_top #(.TICK_DIV(TDIV)) dut (
    .i_sys_clk(clk), .i_rstn(rstn), .i_access_en(en), .i_write_sel(sel), .i_serial_clk(sck),
    .i_data(line), .o_data(dout), .o_data_oe(doe), .i_supply_low(supply_low), .o_freq_output(freq_output),
    .i_avs_address(avs_addr), .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait));
  srt_host_model host (.i_sys_clk(clk), .i_dev_data(dout), .i_dev_oe(doe), .o_access_en(en),
    .o_write_sel(sel), .o_serial_clk(sck), .o_line(line));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      failures++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [51:0] got, input logic [51:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // request held until waitrequest is sampled low at a rising edge; data taken at that edge
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_addr <= a;
    avs_wd   <= d;
    avs_rd   <= ~w;
    avs_wr   <= w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_wait !== 1'b0 && n < 100);
    q = avs_rdata;
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
    // idle edge so the next call never re-raises a strobe in the same time step
    @(posedge clk);
    if (n >= 100) begin
      failures++;
      $display("Error at %0t: avalon request not answered", $time);
    end
  endtask : av
  task automatic rd_time(output logic [51:0] f);
    logic [31:0] lo, hi;
    av(1'b0, SRT_REG_TIME_LO, 32'h0, lo);
    av(1'b0, SRT_REG_TIME_HI, 32'h0, hi);
    f = {hi[19:0], lo};
  endtask : rd_time
  task automatic t_reset_vals();
    logic [31:0] q;
    logic [51:0] f;
    av(1'b1, SRT_REG_TIME_LO, 32'hffffffff, q);
    rd_time(f);
    chk(f, F_RST, "reset calendar");
    av(1'b0, SRT_REG_CTRL, 32'h0, q);
    chk(52'(q), 52'h1, "ctrl reset");
  endtask : t_reset_vals
  task automatic t_write_read();
    logic [51:0] f;
    host.xfer(1'b1, 56, F_W, f);
    w_end = cyc;
    rd_time(f);
    chk(f, F_W, "written frame");
    host.xfer(1'b0, 56, 52'h0, f);
    chk(f, F_W, "serial read");
  endtask : t_write_read
  task automatic t_rollover();
    logic [51:0] f;
    while (cyc < w_end + 2 * SEC + SEC / 2) @(posedge clk);
    rd_time(f);
    chk(f, F_ROLL, "year rollover");
  endtask : t_rollover
  task automatic t_freq_output();
    int          t0, t1;
    logic [31:0] q;
    logic        seen;
    seen = 1'b0;
    while (freq_output !== 1'b0) @(negedge clk);
    while (freq_output !== 1'b1) @(negedge clk);
    t0 = cyc;
    while (freq_output !== 1'b0) @(negedge clk);
    t1 = cyc;
    while (freq_output !== 1'b1) @(negedge clk);
    chk(52'(t1 - t0), 52'(SEC / 2), "freq_output high");
    chk(52'(cyc - t0), 52'(SEC), "freq_output period");
    @(posedge clk);
    av(1'b1, SRT_REG_CTRL, 32'h0, q);
    repeat (4) @(negedge clk);
    repeat (SEC) begin
      @(negedge clk);
      seen = seen | freq_output;
    end
    @(posedge clk);
    av(1'b1, SRT_REG_CTRL, 32'h1, q);
    av(1'b0, SRT_REG_CTRL, 32'h0, q);
    chk(52'(seen), 52'h0, "freq_output gated off");
    chk(52'(q), 52'h1, "ctrl readback");
  endtask : t_freq_output
  task automatic t_trunc_write();
    logic [51:0] f0, f;
    rd_time(f0);
    host.xfer(1'b1, 30, F_CUT, f);
    rd_time(f);
    chk(52'(f[51:8]), 52'(f0[51:8]), "cut write kept");
  endtask : t_trunc_write
  // a short read must not clear the flag; only a full one does
  task automatic t_low_voltage();
    logic [31:0] q;
    logic [51:0] f;
    supply_low <= 1'b1;
    repeat (SEC / 2 + 200) @(posedge clk);
    supply_low <= 1'b0;
    av(1'b0, SRT_REG_STATUS, 32'h0, q);
    chk(52'(q[2]), 52'h1, "flag set");
    host.xfer(1'b0, 28, 52'h0, f);
    chk(52'(f[27:7]), 52'({4'h6, 16'h0000, 1'b1}), "short read");
    av(1'b0, SRT_REG_STATUS, 32'h0, q);
    chk(52'(q[2]), 52'h1, "flag kept");
    host.xfer(1'b0, 52, 52'h0, f);
    chk(52'(f[7]), 52'h1, "flag read");
    av(1'b0, SRT_REG_STATUS, 32'h0, q);
    chk(52'(q[2]), 52'h0, "flag cleared");
  endtask : t_low_voltage
  initial begin
    rstn       = 1'b0;
    supply_low = 1'b0;
    avs_addr   = 4'h0;
    avs_rd     = 1'b0;
    avs_wr     = 1'b0;
    avs_wd     = 32'h0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset_vals();
    t_write_read();
    t_rollover();
    t_freq_output();
    t_trunc_write();
    t_low_voltage();
    finish_test();
  end
endmodule : srt_top_tb
bind srt_top srt_top_chk #(.TICK_DIV(TICK_DIV)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_access_en(i_access_en), .i_write_sel(i_write_sel),
  .i_serial_clk(i_serial_clk), .i_data(i_data), .o_data(o_data), .o_data_oe(o_data_oe),
  .i_supply_low(i_supply_low), .o_freq_output(o_freq_output), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest));
